//--- hw/ddrt_pkg.sv
package ddrt_pkg;
	// byte addresses of the 32-bit words; each 64-bit register is low word then high word
	localparam logic [11:0] ACT_TIMING_OFF = 12'h0B0;
	localparam logic [11:0] ROW_TIMING_OFF = 12'h0C0;
	localparam logic [11:0] REF_INT_OFF    = 12'h110;
	localparam logic [11:0] NARROW_OFF     = 12'h120;
	localparam logic [11:0] ROW_MAX_OFF    = 12'h130;
	localparam logic [11:0] HI_WORD_OFF    = 12'h004;
	localparam logic [63:0] CFG_RST        = 64'h0;
	// field positions inside the 64-bit registers
	localparam int TRC_LSB      = 16;
	localparam int MODE_SET_WAIT_CYCLES_LSB     = 8;
	localparam int FOUR_ACTIVATE_WINDOW_LSB     = 0;
	localparam int REFRESH_DURATION_CYCLES_LSB     = 40;
	localparam int TRCD_LSB     = 32;
	localparam int ROW_OPEN_MIN_CYCLES_LSB = 24;
	localparam int OOR_LEN_LSB  = 16;
	localparam int U_SYND_LSB   = 8;
	localparam int C_SYND_LSB   = 0;
	localparam int REFRESH_INTERVAL_LSB     = 0;
	localparam int NARROW_LSB   = 48;
	localparam int ROW_OPEN_MAX_CYCLES_LSB = 48;
	localparam int POWERDOWN_EXIT_CYCLES_LSB    = 32;
	localparam int DLL_LOCK_CYCLES_LSB     = 16;
	localparam int CLOCK_TO_PRECHARGE_CYCLES_LSB     = 0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// cycles of warning given before a row reaches its longest open time
	localparam logic [15:0] CLOSE_LEAD  = 16'h0004;
endpackage

//--- hw/ddrt_timing_regs.sv
// Summary of operation
// RULE_01: an activate to a bank is permitted only after the activate-to-activate count since the last one.
// RULE_02: after a mode-register set no command is permitted for the mode-set wait count.
// RULE_03: with eight banks, no more than four activates fall within the four-activate window.
// RULE_04: after a refresh no command is permitted for the refresh duration count.
// RULE_05: a column command to a bank waits the row-to-column delay after its activate.
// RULE_06: a row stays open at least the minimum row-active count before precharge is permitted.
// RULE_07: an out-of-range host access records its command length in a read-only field.
// RULE_08: an uncorrectable two-bit ECC error records its syndrome in a read-only field.
// RULE_09: a corrected single-bit ECC error records its syndrome in a separate read-only field.
// RULE_10: refresh is requested periodically at the programmed refresh interval.
// RULE_11: a 16-bit mask decides whether host port 0 takes accesses narrower than 64 bits.
// RULE_12: a close request is raised before a row is open longer than the maximum row-active count.
// RULE_13: after a power-down exit no command is permitted for the power-down exit count.
// RULE_14: column commands wait for the DLL lock count after a DLL reset.
// RULE_15: precharge waits the clock-to-precharge count, in controller clock cycles.
// RULE_16: software writes to the syndrome and bad_range_cmd_len fields are ignored.
// RULE_17: software programs all timing fields for the attached memory before normal traffic.
`timescale 1ns/1ps
module ddrt_timing_regs #(
	parameter int NB = 8,
	parameter int AW = 12
) (
	input  wire logic          ref_clk,
	input  wire logic          resetn,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          eight_banks,
	input  wire logic          cmd_act,
	input  wire logic          cmd_col,
	input  wire logic          cmd_pre,
	input  wire logic          cmd_pre_all,
	input  wire logic          cmd_ref,
	input  wire logic          cmd_mrs,
	input  wire logic          cmd_pdx,
	input  wire logic          cmd_dll_rst,
	input  wire logic [$clog2(NB)-1:0] cmd_bank,
	input  wire logic          ecc_c_evt,
	input  wire logic [7:0]    corrected_syndrome,
	input  wire logic          ecc_u_evt,
	input  wire logic [7:0]    uncorrectable_syndrome,
	input  wire logic          oor_evt,
	input  wire logic [7:0]    oor_len,
	output logic               cmd_ok,
	output logic [NB-1:0]      act_ok,
	output logic [NB-1:0]      col_ok,
	output logic [NB-1:0]      pre_ok,
	output logic [NB-1:0]      close_req,
	output logic               ref_due,
	output logic [15:0]        port0_narrow_mask
);
	localparam int BW = $clog2(NB);

	typedef struct packed {
		logic [63:0]           act_cfg;
		logic [63:0]           row_cfg;
		logic [63:0]           ref_cfg;
		logic [63:0]           nar_cfg;
		logic [63:0]           max_cfg;
		logic                  aw_ok;
		logic                  aw_rdy;
		logic [AW-1:0]         aw_addr;
		logic                  w_ok;
		logic                  w_rdy;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  ar_rdy;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic [NB-1:0]         open;
		logic [NB-1:0][15:0]   rc;
		logic [NB-1:0][15:0]   rcd;
		logic [NB-1:0][15:0]   rmin;
		logic [NB-1:0][15:0]   rmax;
		logic [3:0][15:0]      faw;
		logic [15:0]           blk;
		logic [15:0]           dll;
		logic [15:0]           cpd;
		logic [13:0]           refcnt;
		logic                  ref_due;
		logic                  cmd_ok;
		logic [NB-1:0]         act_ok;
		logic [NB-1:0]         col_ok;
		logic [NB-1:0]         pre_ok;
		logic [NB-1:0]         close_req;
	} ddrt_st_t;

	ddrt_st_t q;
	ddrt_st_t d;

	// a count of n permits the next command n cycles after the one that loaded it
	function automatic logic [15:0] ddrt_ld(input logic [15:0] n);
		ddrt_ld = (n == 16'h0000) ? 16'h0000 : n - 16'h0001;
	endfunction

	function automatic logic [15:0] ddrt_dec(input logic [15:0] n);
		ddrt_dec = (n == 16'h0000) ? 16'h0000 : n - 16'h0001;
	endfunction

	function automatic logic [15:0] ddrt_max(input logic [15:0] a, input logic [15:0] b);
		ddrt_max = (a > b) ? a : b;
	endfunction

	function automatic logic [31:0] ddrt_wm(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  st
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		ddrt_wm = r;
	endfunction

	logic [15:0] t_rc;
	logic [15:0] t_mrd;
	logic [15:0] t_faw;
	logic [15:0] t_rfc;
	logic [15:0] t_rcd;
	logic [15:0] t_rmin;
	logic [13:0] t_ref;
	logic [15:0] t_rmax;
	logic [15:0] t_pdex;
	logic [15:0] t_dll;
	logic [15:0] t_cpd;

	assign t_rc   = {11'h000, q.act_cfg[ddrt_pkg::TRC_LSB +: 5]};
	assign t_mrd  = {11'h000, q.act_cfg[ddrt_pkg::MODE_SET_WAIT_CYCLES_LSB +: 5]};
	assign t_faw  = {11'h000, q.act_cfg[ddrt_pkg::FOUR_ACTIVATE_WINDOW_LSB +: 5]};
	assign t_rfc  = {8'h00, q.row_cfg[ddrt_pkg::REFRESH_DURATION_CYCLES_LSB +: 8]};
	assign t_rcd  = {8'h00, q.row_cfg[ddrt_pkg::TRCD_LSB +: 8]};
	assign t_rmin = {8'h00, q.row_cfg[ddrt_pkg::ROW_OPEN_MIN_CYCLES_LSB +: 8]};
	assign t_ref  = q.ref_cfg[ddrt_pkg::REFRESH_INTERVAL_LSB +: 14];
	assign t_rmax = q.max_cfg[ddrt_pkg::ROW_OPEN_MAX_CYCLES_LSB +: 16];
	assign t_pdex = q.max_cfg[ddrt_pkg::POWERDOWN_EXIT_CYCLES_LSB +: 16];
	assign t_dll  = q.max_cfg[ddrt_pkg::DLL_LOCK_CYCLES_LSB +: 16];
	assign t_cpd  = q.max_cfg[ddrt_pkg::CLOCK_TO_PRECHARGE_CYCLES_LSB +: 16];

	always_comb begin
		logic        glob;
		logic        faw_ok;
		logic        hit;
		logic [31:0] wl;
		glob = 1'b0;
		faw_ok = 1'b0;
		hit = 1'b0;
		wl = 32'h0000_0000;
		d = q;

		// register bus: address and data are taken independently, answered together
		if (s_axi_awvalid && q.aw_rdy) begin
			d.aw_ok = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.w_rdy) begin
			d.w_ok = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_ok && q.w_ok && !q.bvalid) begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = ddrt_pkg::RESP_OKAY;
			if (q.aw_addr == AW'(ddrt_pkg::ACT_TIMING_OFF)) begin
				d.act_cfg[31:0] = ddrt_wm(q.act_cfg[31:0], q.w_data, q.w_strb);
			end else if (q.aw_addr == AW'(ddrt_pkg::ACT_TIMING_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.act_cfg[63:32] = ddrt_wm(q.act_cfg[63:32], q.w_data, q.w_strb);
			end else if (q.aw_addr == AW'(ddrt_pkg::ROW_TIMING_OFF)) begin
				wl = ddrt_wm(q.row_cfg[31:0], q.w_data, q.w_strb);
				d.row_cfg[31:24] = wl[31:24]; // RULE_16
			end else if (q.aw_addr == AW'(ddrt_pkg::ROW_TIMING_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.row_cfg[63:32] = ddrt_wm(q.row_cfg[63:32], q.w_data, q.w_strb);
			end else if (q.aw_addr == AW'(ddrt_pkg::REF_INT_OFF)) begin
				d.ref_cfg[31:0] = ddrt_wm(q.ref_cfg[31:0], q.w_data, q.w_strb);
			end else if (q.aw_addr == AW'(ddrt_pkg::REF_INT_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.ref_cfg[63:32] = ddrt_wm(q.ref_cfg[63:32], q.w_data, q.w_strb);
			end else if (q.aw_addr == AW'(ddrt_pkg::NARROW_OFF)) begin
				d.nar_cfg[31:0] = ddrt_wm(q.nar_cfg[31:0], q.w_data, q.w_strb);
			end else if (q.aw_addr == AW'(ddrt_pkg::NARROW_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.nar_cfg[63:32] = ddrt_wm(q.nar_cfg[63:32], q.w_data, q.w_strb);
			end else if (q.aw_addr == AW'(ddrt_pkg::ROW_MAX_OFF)) begin
				d.max_cfg[31:0] = ddrt_wm(q.max_cfg[31:0], q.w_data, q.w_strb);
			end else if (q.aw_addr == AW'(ddrt_pkg::ROW_MAX_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.max_cfg[63:32] = ddrt_wm(q.max_cfg[63:32], q.w_data, q.w_strb);
			end else begin
				d.bresp = ddrt_pkg::RESP_SLVERR;
			end
		end
		d.aw_rdy = !d.aw_ok;
		d.w_rdy = !d.w_ok;

		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.ar_rdy) begin
			d.rvalid = 1'b1;
			d.rresp = ddrt_pkg::RESP_OKAY;
			if (s_axi_araddr == AW'(ddrt_pkg::ACT_TIMING_OFF)) begin
				d.rdata = q.act_cfg[31:0];
			end else if (s_axi_araddr == AW'(ddrt_pkg::ACT_TIMING_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.rdata = q.act_cfg[63:32];
			end else if (s_axi_araddr == AW'(ddrt_pkg::ROW_TIMING_OFF)) begin
				d.rdata = q.row_cfg[31:0];
			end else if (s_axi_araddr == AW'(ddrt_pkg::ROW_TIMING_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.rdata = q.row_cfg[63:32];
			end else if (s_axi_araddr == AW'(ddrt_pkg::REF_INT_OFF)) begin
				d.rdata = q.ref_cfg[31:0];
			end else if (s_axi_araddr == AW'(ddrt_pkg::REF_INT_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.rdata = q.ref_cfg[63:32];
			end else if (s_axi_araddr == AW'(ddrt_pkg::NARROW_OFF)) begin
				d.rdata = q.nar_cfg[31:0];
			end else if (s_axi_araddr == AW'(ddrt_pkg::NARROW_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.rdata = q.nar_cfg[63:32];
			end else if (s_axi_araddr == AW'(ddrt_pkg::ROW_MAX_OFF)) begin
				d.rdata = q.max_cfg[31:0];
			end else if (s_axi_araddr == AW'(ddrt_pkg::ROW_MAX_OFF + ddrt_pkg::HI_WORD_OFF)) begin
				d.rdata = q.max_cfg[63:32];
			end else begin
				d.rdata = 32'h0000_0000;
				d.rresp = ddrt_pkg::RESP_SLVERR;
			end
		end
		d.ar_rdy = !d.rvalid;

		// error capture; last event wins, older values are overwritten
		if (oor_evt) begin
			d.row_cfg[ddrt_pkg::OOR_LEN_LSB +: 8] = oor_len; // RULE_07
		end
		if (ecc_u_evt) begin
			d.row_cfg[ddrt_pkg::U_SYND_LSB +: 8] = uncorrectable_syndrome; // RULE_08
		end
		if (ecc_c_evt) begin
			d.row_cfg[ddrt_pkg::C_SYND_LSB +: 8] = corrected_syndrome; // RULE_09
		end

		// commands that hold off the whole device, then the DLL lock and clock-to-precharge waits
		d.blk = ddrt_dec(q.blk);
		if (cmd_mrs) begin
			d.blk = ddrt_max(d.blk, ddrt_ld(t_mrd)); // RULE_02
		end
		if (cmd_ref) begin
			d.blk = ddrt_max(d.blk, ddrt_ld(t_rfc)); // RULE_04
		end
		if (cmd_pdx) begin
			d.blk = ddrt_max(d.blk, ddrt_ld(t_pdex)); // RULE_13
		end
		d.dll = cmd_dll_rst ? ddrt_ld(t_dll) : ddrt_dec(q.dll); // RULE_14
		d.cpd = cmd_pdx ? ddrt_ld(t_cpd) : ddrt_dec(q.cpd); // RULE_15

		// four-activate window: four countdowns, the oldest gates the next activate
		for (int i = 0; i < 4; i++) begin
			d.faw[i] = ddrt_dec(q.faw[i]);
		end
		if (cmd_act) begin
			d.faw = {d.faw[2:0], ddrt_ld(t_faw)}; // RULE_03
		end

		// refresh interval; a zero interval disables the refresh timer
		if (cmd_ref) begin
			d.ref_due = 1'b0;
		end
		if (t_ref == 14'h0000) begin
			d.refcnt = 14'h0000;
		end else if (q.refcnt == 14'h0000) begin
			d.refcnt = t_ref - 14'h0001; // RULE_10
			d.ref_due = 1'b1;
		end else begin
			d.refcnt = q.refcnt - 14'h0001;
		end

		glob = (d.blk == 16'h0000);
		faw_ok = !eight_banks || (d.faw[3] == 16'h0000); // RULE_03
		d.cmd_ok = glob;
		for (int b = 0; b < NB; b++) begin
			hit = (cmd_bank == BW'(b));
			d.rc[b] = ddrt_dec(q.rc[b]);
			d.rcd[b] = ddrt_dec(q.rcd[b]);
			d.rmin[b] = ddrt_dec(q.rmin[b]);
			d.rmax[b] = ddrt_dec(q.rmax[b]);
			if (cmd_act && hit) begin
				d.open[b] = 1'b1;
				d.rc[b] = ddrt_ld(t_rc); // RULE_01
				d.rcd[b] = ddrt_ld(t_rcd); // RULE_05
				d.rmin[b] = ddrt_ld(t_rmin); // RULE_06
				d.rmax[b] = t_rmax; // RULE_12
			end
			if (cmd_pre && (hit || cmd_pre_all)) begin
				d.open[b] = 1'b0;
			end
			d.act_ok[b] = glob && faw_ok && !d.open[b] && (d.rc[b] == 16'h0000); // RULE_01
			// column commands also wait for the DLL after a reset of it
			d.col_ok[b] = glob && d.open[b] && (d.rcd[b] == 16'h0000)
				&& (d.dll == 16'h0000); // RULE_05 RULE_14
			d.pre_ok[b] = glob && d.open[b] && (d.rmin[b] == 16'h0000)
				&& (d.cpd == 16'h0000); // RULE_06 RULE_15
			// a zero maximum disables the close request
			d.close_req[b] = d.open[b] && (t_rmax != 16'h0000)
				&& (d.rmax[b] <= ddrt_pkg::CLOSE_LEAD); // RULE_12
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.act_cfg <= ddrt_pkg::CFG_RST;
			q.row_cfg <= ddrt_pkg::CFG_RST;
			q.ref_cfg <= ddrt_pkg::CFG_RST;
			q.nar_cfg <= ddrt_pkg::CFG_RST;
			q.max_cfg <= ddrt_pkg::CFG_RST;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready     = q.aw_rdy;
	assign s_axi_wready      = q.w_rdy;
	assign s_axi_bresp       = q.bresp;
	assign s_axi_bvalid      = q.bvalid;
	assign s_axi_arready     = q.ar_rdy;
	assign s_axi_rdata       = q.rdata;
	assign s_axi_rresp       = q.rresp;
	assign s_axi_rvalid      = q.rvalid;
	assign cmd_ok            = q.cmd_ok;
	assign act_ok            = q.act_ok;
	assign col_ok            = q.col_ok;
	assign pre_ok            = q.pre_ok;
	assign close_req         = q.close_req;
	assign ref_due           = q.ref_due;
	assign port0_narrow_mask = q.nar_cfg[ddrt_pkg::NARROW_LSB +: 16]; // RULE_11
endmodule

//--- sim/ddrt_timing_regs_monitor.sv
`timescale 1ns/1ps
module ddrt_timing_regs_monitor #(
	parameter int NB = 8
) (
	input wire logic			ref_clk,
	input wire logic			resetn,
	input wire logic			s_axi_bvalid,
	input wire logic			s_axi_bready,
	input wire logic			cmd_act,
	input wire logic			cmd_pre,
	input wire logic			cmd_ref,
	input wire logic [$clog2(NB)-1:0]	cmd_bank,
	input wire logic			cmd_ok,
	input wire logic [NB-1:0]		act_ok,
	input wire logic [NB-1:0]		col_ok,
	input wire logic [NB-1:0]		pre_ok,
	input wire logic [NB-1:0]		close_req,
	input wire logic			ref_due,
	input wire logic [15:0]			port0_narrow_mask
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_act_blk; cmd_act |=> !act_ok[$past(cmd_bank)]; endproperty
	a_act_blk: assert property (p_act_blk) else $error("activate permit not dropped");
	property p_hold; !cmd_ok |-> (act_ok | col_ok | pre_ok) == '0; endproperty
	a_hold: assert property (p_hold) else $error("permit during hold-off");
	property p_col; cmd_act |=> !col_ok[$past(cmd_bank)]; endproperty
	a_col: assert property (p_col) else $error("column permit right after activate");
	property p_pre; cmd_pre |=> !pre_ok[$past(cmd_bank)]; endproperty
	a_pre: assert property (p_pre) else $error("precharge permit on closed bank");
	// an open bank never allows an activate, so a close request implies a low permit
	property p_close; close_req != '0 |-> (close_req & act_ok) == '0; endproperty
	a_close: assert property (p_close) else $error("close request on idle bank");
	property p_ref; ref_due && !cmd_ref |=> ref_due; endproperty
	a_ref: assert property (p_ref) else $error("refresh due lost without refresh");
	property p_mask; !$stable(port0_narrow_mask) |-> $rose(s_axi_bvalid); endproperty
	a_mask: assert property (p_mask) else $error("narrow mask moved without write");
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdone: assert property (p_bdone) else $error("write answer repeated");
endmodule
bind ddrt_timing_regs ddrt_timing_regs_monitor #(.NB(NB)) i_ddrt_timing_regs_monitor (
	.ref_clk, .resetn, .s_axi_bvalid, .s_axi_bready, .cmd_act, .cmd_pre, .cmd_ref, .cmd_bank,
	.cmd_ok, .act_ok, .col_ok, .pre_ok, .close_req, .ref_due, .port0_narrow_mask
);

//--- sim/ddrt_mem_model.sv
`timescale 1ns/1ps
module ddrt_mem_model (
	input  wire logic	ref_clk,
	input  wire logic	resetn,
	input  wire logic [1:0]	inj_bits,
	input  wire logic [7:0]	inj_synd,
	output logic		ecc_c_evt,
	output logic		ecc_u_evt,
	output logic [7:0]	corrected_syndrome,
	output logic [7:0]	uncorrectable_syndrome
);
	logic [7:0] synd_q;
	// syndrome lines toggle between reports, so a capture off the pulse is caught
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ecc_c_evt <= 1'b0;
			ecc_u_evt <= 1'b0;
			synd_q <= 8'h00;
		end else begin
			ecc_c_evt <= inj_bits == 2'h1;
			ecc_u_evt <= inj_bits == 2'h2;
			synd_q <= (inj_bits != 2'h0) ? inj_synd : ~synd_q;
		end
	end
	assign corrected_syndrome = synd_q;
	assign uncorrectable_syndrome = synd_q;
endmodule

//--- sim/ddrt_timing_regs_tb.sv
`timescale 1ns/1ps
module ddrt_timing_regs_tb;
	logic		ref_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic		s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic		s_axi_rready, eight_banks, cmd_act, cmd_col, cmd_pre, cmd_pre_all, cmd_ref;
	logic		cmd_mrs, cmd_pdx, cmd_dll_rst, ecc_c_evt, ecc_u_evt, oor_evt, cmd_ok, ref_due;
	logic [1:0]	s_axi_bresp, s_axi_rresp, inj_bits, rsp;
	logic [2:0]	cmd_bank;
	logic [3:0]	s_axi_wstrb;
	logic [7:0]	corrected_syndrome, uncorrectable_syndrome, oor_len, inj_synd, act_ok, col_ok, pre_ok, close_req;
	logic [11:0]	s_axi_awaddr, s_axi_araddr;
	logic [15:0]	port0_narrow_mask;
	logic [31:0]	s_axi_wdata, s_axi_rdata, rd_d;
	int		failures = 0;
	int		n_checks = 0;
	logic [11:0]	ra [6] = '{12'h0B0, 12'h0C4, 12'h110, 12'h124, 12'h130, 12'h134};
	logic [31:0]	rm [6] = '{32'h001F1F1F, 32'h0000FFFF, 32'h00003FFF, 32'hFFFF0000,
		32'hFFFFFFFF, 32'hFFFFFFFF};

	ddrt_timing_regs i_ddrt_timing_regs (.*);
	ddrt_mem_model i_ddrt_mem_model (.*);

	always #12.5 ref_clk = ~ref_clk;

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// every polling loop in the bench goes through here so a hang ends the run
	task automatic tick(inout int n);
		@(posedge ref_clk);
		n++;
		if (n > 400) begin
			chk(32'(n), 32'd400);
			final_report();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			tick(n);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// let an edge pass so the next call never re-raises bready in this step
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [11:0] a);
		int n = 0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			tick(n);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd_d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	// pulse one command, then count edges until cmd_ok returns, or until col_ok of bank 0 rises after an activate
	task automatic timed(input int k, input int e);
		int n = 0;
		{cmd_act, cmd_mrs, cmd_ref, cmd_pdx} <= 4'(8 >> k);
		@(posedge ref_clk);
		{cmd_act, cmd_mrs, cmd_ref, cmd_pdx} <= 4'h0;
		#1;
		while (!(k == 0 ? col_ok[0] : cmd_ok)) begin
			tick(n);
			#1;
		end
		chk(32'(n), 32'(e));
	endtask

	task automatic inject(input logic [1:0] b, input logic [7:0] s);
		inj_bits <= b;
		inj_synd <= s;
		@(posedge ref_clk);
		inj_bits <= 2'h0;
		repeat (3) @(posedge ref_clk);
	endtask

	initial begin
		logic [31:0] d;
		logic [31:0] v;
		int n;
		int tv [4];
		ref_clk = 1'b0;
		resetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{cmd_act, cmd_col, cmd_pre, cmd_pre_all, cmd_ref, cmd_mrs, cmd_pdx, cmd_dll_rst} = 8'h00;
		{oor_evt, eight_banks, cmd_bank, inj_bits} = 7'h20;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, inj_synd, oor_len} = '0;
		s_axi_wstrb = 4'hF;
		v = $urandom(32'h56BEFE89);
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(rd_d, 32'h0);
		end
		rd(12'h200);
		chk({rd_d[29:0], rsp}, {30'h0, ddrt_pkg::RESP_SLVERR});
		wr(12'h200, 32'hFFFFFFFF);
		chk({30'h0, rsp}, {30'h0, ddrt_pkg::RESP_SLVERR});
		repeat (3) foreach (ra[i]) begin
			d = $urandom;
			wr(ra[i], d);
			rd(ra[i]);
			chk(rd_d & rm[i], d & rm[i]);
			if (i == 3) chk({16'h0, port0_narrow_mask}, {16'h0, d[31:16]});
		end
		rd(12'h0C0);
		chk(rd_d, 32'h0);
		v = $urandom;
		inject(2'h1, v[7:0]);
		inject(2'h2, v[15:8]);
		oor_evt <= 1'b1;
		oor_len <= v[23:16];
		@(posedge ref_clk);
		oor_evt <= 1'b0;
		oor_len <= ~v[23:16];
		@(posedge ref_clk);
		rd(12'h0C0);
		chk(rd_d, {8'h00, v[23:0]});
		d = $urandom;
		wr(12'h0C0, d);
		rd(12'h0C0);
		chk(rd_d, {d[31:24], v[23:0]});
		// first pass takes the largest row-to-column, mode-set and refresh values and a power-down exit of 300, later passes random ones
		tv = '{255, 31, 255, 300};
		for (int p = 0; p < 3; p++) begin
			wr(12'h0B0, 32'(tv[1]) << 8);
			wr(12'h0C4, {16'h0000, tv[2][7:0], tv[0][7:0]});
			wr(12'h130, 32'h0);
			wr(12'h134, {16'h0010, tv[3][15:0]});
			timed(0, tv[0] - 1);
			cmd_pre <= 1'b1;
			@(posedge ref_clk);
			cmd_pre <= 1'b0;
			timed(1, tv[1] - 1);
			timed(2, tv[2] - 1);
			timed(3, tv[3] - 1);
			tv = '{$urandom_range(60, 2), $urandom_range(31, 2), $urandom_range(60, 2),
				$urandom_range(60, 2)};
		end
		v = $urandom_range(60, 20);
		// a zero interval parks the timer so the new interval starts from a clean reload
		wr(12'h110, 32'h0);
		wr(12'h110, v);
		cmd_ref <= 1'b1;
		@(posedge ref_clk);
		cmd_ref <= 1'b0;
		n = 0;
		do tick(n); while (!ref_due);
		cmd_ref <= 1'b1;
		n = 0;
		do begin
			tick(n);
			cmd_ref <= 1'b0;
		end while (ref_due);
		while (!ref_due) tick(n);
		chk(32'(n), v);
		final_report();
	end
endmodule
